// >>> logic/scs_defines.svh
// offsets, field positions, reset values and timing counts of the clock select block
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_OFF_SEL        12'h000
`define SCS_OFF_FRC        12'h004
`define SCS_OFF_FXT        12'h008
`define SCS_OFF_SXT        12'h00c
`define SCS_OFF_IRQ_STAT   12'h010
`define SCS_OFF_IRQ_MASK   12'h014
`define SCS_SEL_CODE_HI    7
`define SCS_SEL_CODE_LO    5
`define SCS_SEL_HSRC_BIT   3
`define SCS_SEL_LSRC_BIT   2
`define SCS_SEL_HIDLE_BIT  1
`define SCS_SEL_LIDLE_BIT  0
`define SCS_FRC_FREQ_HI    3
`define SCS_FRC_FREQ_LO    2
`define SCS_FRC_FLAG_BIT   1
`define SCS_FRC_EN_BIT     0
`define SCS_FXT_MODE_BIT   2
`define SCS_XT_FLAG_BIT    1
`define SCS_XT_EN_BIT      0
`define SCS_SEL_RESET      8'h00
`define SCS_FRC_RESET      8'h01
`define SCS_FXT_RESET      8'h00
`define SCS_SXT_RESET      8'h00
`define SCS_IRQ_RESET      3'h0
`define SCS_CODE_SUB       3'h7
`define SCS_SWITCH_TICKS   3'h4
`define SCS_CLK_PERIOD_NS  10
`define SCS_FRC_SETTLE_NS  1000
`define SCS_FRC_SETTLE_CYC ((`SCS_FRC_SETTLE_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS)
`endif

// >>> logic/scs_pkg.sv
// types shared by the clock select block
package scs_pkg;
  typedef enum logic [2:0] {SCS_FAST, SCS_SLOW, SCS_SLEEP, SCS_IDLE_LOW_ONLY,
                            SCS_IDLE_BOTH_CLOCKS, SCS_IDLE_HIGH_ONLY} scs_mode_t;
  typedef enum logic [1:0] {SCS_SW_RUN, SCS_SW_COUNT, SCS_SW_HOLD} scs_sw_state_t;
  typedef struct packed {
    logic [2:0] sys_clock_selector;
    logic       high_source_select;
    logic       low_source_select;
    logic       high_idle_enable;
    logic       low_idle_enable;
  } scs_sel_t;
  typedef struct packed {
    logic       run_internal_fast;
    logic       run_external_fast;
    logic       run_internal_slow;
    logic       run_external_slow;
    logic [1:0] fast_rc_freq;
  } scs_osc_ctl_t;
endpackage

// >>> logic/scs_clk_switch.sv
// glitch-free handover of the system clock enable between candidate rates
`timescale 1ns/1ps
module scs_clk_switch
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // candidate rate ticks and request
  input  wire logic [7:0] cand_tick,
  input  wire logic [2:0] req_code,
  // system clock enable and status
  output logic            sys_tick,
  output logic [2:0]      cur_code,
  output logic            busy,
  output logic            done
);
`include "scs_defines.svh"

  scs_sw_state_t state_r, state_nxt;
  logic [2:0]    cur_r, cur_nxt;
  logic [2:0]    cnt_r, cnt_nxt;

  // four current periods run on, then output holds until a target edge
  always_comb
  begin
    state_nxt = state_r;
    cur_nxt   = cur_r;
    cnt_nxt   = cnt_r;
    sys_tick  = 1'b0;
    done      = 1'b0;
    case (state_r)
      SCS_SW_RUN:
      begin
        sys_tick = cand_tick[cur_r];
        if (req_code != cur_r)
        begin
          state_nxt = SCS_SW_COUNT;
          cnt_nxt   = 3'h0;
        end
      end
      SCS_SW_COUNT:
      begin
        sys_tick = cand_tick[cur_r];
        if (cand_tick[cur_r])
        begin
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r + 3'h1 == `SCS_SWITCH_TICKS)
            state_nxt = SCS_SW_HOLD;
        end
      end
      SCS_SW_HOLD:
      begin
        // no tick leaves while waiting, so no phase is ever shortened
        if (cand_tick[req_code])
        begin
          sys_tick  = 1'b1;
          cur_nxt   = req_code;
          done      = 1'b1;
          state_nxt = SCS_SW_RUN;
        end
      end
      default:
        state_nxt = SCS_SW_RUN;
    endcase
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= SCS_SW_RUN;
      cur_r   <= 3'h0;
      cnt_r   <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r   <= cur_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign cur_code = cur_r;
  assign busy     = (state_r != SCS_SW_RUN);

  // no tick escapes while holding for the target edge
  property p_hold_silent;
    @(posedge pclk) disable iff (!presetn)
      (state_r == SCS_SW_HOLD && !cand_tick[req_code]) |-> !sys_tick;
  endproperty
  a_hold_silent: assert property (p_hold_silent)
    else $error("tick left during hold");

  // entering hold needs exactly four current ticks
  property p_four_ticks;
    @(posedge pclk) disable iff (!presetn)
      (state_r == SCS_SW_COUNT && state_nxt == SCS_SW_HOLD) |-> cnt_r == 3'h3;
  endproperty
  a_four_ticks: assert property (p_four_ticks)
    else $error("switch left count early");
endmodule

// >>> logic/scs_top.sv
// system clock select and oscillator control with apb registers
// Functional notes
// - selector codes divide fast clock, 111 picks sub
// - unimplemented bits ignore writes, read zero
// - high source bit: 0 fast rc, 1 crystal
// - low source bit: 0 slow rc, 1 crystal
// - high idle bit keeps fast osc during halt
// - low idle bit keeps slow osc during halt
// - switch ends within four periods plus bounded slack
// - fast rc field: 01 8M, 10 12M, 11 4M
// - new fast rc frequency applies once stable
// - enabling fast rc clears flag, sets after settling
// - fast rc enable bit resets to one
// - halt picks sleep or idle from idle bits
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module scs_top
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // oscillator ticks, one pclk wide, and crystal ready levels
  input  wire logic         internal_fast_osc,
  input  wire logic         external_fast_crystal,
  input  wire logic         internal_slow_osc,
  input  wire logic         external_slow_crystal,
  input  wire logic         fast_crystal_ready,
  input  wire logic         slow_crystal_ready,
  // cpu power handshake
  input  wire logic         halt_req,
  input  wire logic         wake_req,
  // clock outputs and oscillator controls
  output logic              sys_tick,
  output logic              fast_tick,
  output logic              sub_tick,
  output scs_osc_ctl_t      osc_ctl,
  output scs_mode_t         power_mode,
  output logic              switch_busy,
  // interrupt
  output logic              irq
);
`include "scs_defines.svh"

  localparam logic [7:0] FRC_SETTLE = 8'(`SCS_FRC_SETTLE_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // register state
  scs_sel_t     sel_r, sel_nxt;
  logic [1:0]   frc_freq_r, frc_freq_nxt;
  logic [1:0]   frc_applied_r, frc_applied_nxt;
  logic         frc_en_r, frc_en_nxt;
  logic         frc_flag_r, frc_flag_nxt;
  logic [7:0]   frc_cnt_r, frc_cnt_nxt;
  logic         fxt_mode_r, fxt_mode_nxt;
  logic         fxt_en_r, fxt_en_nxt;
  logic         sxt_en_r, sxt_en_nxt;
  logic [2:0]   irq_stat_r, irq_stat_nxt;
  logic [2:0]   irq_mask_r, irq_mask_nxt;
  logic         halted_r, halted_nxt;
  logic         ack_r, ack_nxt;
  logic [31:0]  prdata_r, prdata_nxt;
  logic         slverr_r, slverr_nxt;
  logic [5:0]   div_r, div_nxt;

  logic         acc, wr, mapped;
  logic [31:0]  rd_val;
  logic         fh_raw, fsub_raw, fh_run, fsub_run;
  logic [7:0]   cand_tick;
  logic [2:0]   cur_code;
  logic         sw_done, sw_tick;
  logic [2:0]   events;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state so read data comes from a flip-flop
  assign acc = psel & penable & !ack_r;
  assign wr  = psel & penable & ack_r & pwrite;
  assign mapped = (paddr == `SCS_OFF_SEL) || (paddr == `SCS_OFF_FRC) ||
                  (paddr == `SCS_OFF_FXT) || (paddr == `SCS_OFF_SXT) ||
                  (paddr == `SCS_OFF_IRQ_STAT) || (paddr == `SCS_OFF_IRQ_MASK);

  // read view; unimplemented bits keep the zero default
  always_comb
  begin
    rd_val = 32'h0;
    case (paddr)
      `SCS_OFF_SEL:      rd_val[7:0] = {sel_r.sys_clock_selector, 1'b0,
                                        sel_r.high_source_select, sel_r.low_source_select,
                                        sel_r.high_idle_enable, sel_r.low_idle_enable};
      `SCS_OFF_FRC:      rd_val[3:0] = {frc_freq_r, frc_flag_r, frc_en_r};
      `SCS_OFF_FXT:      rd_val[2:0] = {fxt_mode_r, fxt_en_r & fast_crystal_ready, fxt_en_r};
      `SCS_OFF_SXT:      rd_val[1:0] = {sxt_en_r & slow_crystal_ready, sxt_en_r};
      `SCS_OFF_IRQ_STAT: rd_val[2:0] = irq_stat_r;
      `SCS_OFF_IRQ_MASK: rd_val[2:0] = irq_mask_r;
      default:           rd_val = 32'h0;
    endcase
  end

  // bus answer registers
  always_comb
  begin
    ack_nxt    = acc;
    prdata_nxt = acc ? rd_val : prdata_r;
    slverr_nxt = acc ? !mapped : 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers and write effects
  always_comb
  begin
    sel_nxt      = sel_r;
    frc_freq_nxt = frc_freq_r;
    frc_en_nxt   = frc_en_r;
    fxt_mode_nxt = fxt_mode_r;
    fxt_en_nxt   = fxt_en_r;
    sxt_en_nxt   = sxt_en_r;
    irq_mask_nxt = irq_mask_r;
    if (wr)
    begin
      case (paddr)
        `SCS_OFF_SEL:
        begin
          // bit 4 has no storage, so a write there is dropped
          sel_nxt.sys_clock_selector = pwdata[`SCS_SEL_CODE_HI:`SCS_SEL_CODE_LO];
          sel_nxt.high_source_select = pwdata[`SCS_SEL_HSRC_BIT];
          sel_nxt.low_source_select  = pwdata[`SCS_SEL_LSRC_BIT];
          sel_nxt.high_idle_enable   = pwdata[`SCS_SEL_HIDLE_BIT];
          sel_nxt.low_idle_enable    = pwdata[`SCS_SEL_LIDLE_BIT];
        end
        `SCS_OFF_FRC:
        begin
          frc_freq_nxt = pwdata[`SCS_FRC_FREQ_HI:`SCS_FRC_FREQ_LO];
          frc_en_nxt   = pwdata[`SCS_FRC_EN_BIT];
        end
        `SCS_OFF_FXT:
        begin
          // drive strength may not change under a running crystal
          if (!fxt_en_r)
            fxt_mode_nxt = pwdata[`SCS_FXT_MODE_BIT];
          fxt_en_nxt = pwdata[`SCS_XT_EN_BIT];
        end
        `SCS_OFF_SXT:      sxt_en_nxt   = pwdata[`SCS_XT_EN_BIT];
        `SCS_OFF_IRQ_MASK: irq_mask_nxt = pwdata[2:0];
        default:           sel_nxt      = sel_r;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fast rc settling: enable or retune restarts the stable flag
  always_comb
  begin
    frc_flag_nxt    = frc_flag_r;
    frc_cnt_nxt     = frc_cnt_r;
    frc_applied_nxt = frc_applied_r;
    if (!frc_en_nxt)
    begin
      frc_flag_nxt = 1'b0;
      frc_cnt_nxt  = 8'h0;
    end
    else if ((frc_en_nxt && !frc_en_r) || (frc_freq_nxt != frc_freq_r))
    begin
      frc_flag_nxt = 1'b0;
      frc_cnt_nxt  = 8'h0;
    end
    else if (!frc_flag_r)
    begin
      frc_cnt_nxt = frc_cnt_r + 8'h1;
      if (frc_cnt_r + 8'h1 >= FRC_SETTLE)
      begin
        frc_flag_nxt    = 1'b1;
        frc_applied_nxt = frc_freq_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // halt state and operating mode
  always_comb
  begin
    halted_nxt = halted_r;
    if (halt_req)
      halted_nxt = 1'b1;
    else if (wake_req)
      halted_nxt = 1'b0;
  end

  // mode from halt and idle bits
  always_comb
  begin
    if (!halted_r)
      power_mode = (sel_r.sys_clock_selector == `SCS_CODE_SUB) ? SCS_SLOW : SCS_FAST;
    else
      case ({sel_r.high_idle_enable, sel_r.low_idle_enable})
        2'b00:   power_mode = SCS_SLEEP;
        2'b01:   power_mode = SCS_IDLE_LOW_ONLY;
        2'b11:   power_mode = SCS_IDLE_BOTH_CLOCKS;
        2'b10:   power_mode = SCS_IDLE_HIGH_ONLY;
        default: power_mode = SCS_SLEEP;
      endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // source routing and oscillator run controls
  assign fh_run   = !halted_r || sel_r.high_idle_enable;
  assign fsub_run = !halted_r || sel_r.low_idle_enable;
  assign fh_raw   = sel_r.high_source_select ? external_fast_crystal
                                             : internal_fast_osc;
  assign fsub_raw = sel_r.low_source_select ? external_slow_crystal
                                            : internal_slow_osc;
  assign fast_tick = fh_raw & fh_run;
  assign sub_tick  = fsub_raw & fsub_run;

  assign osc_ctl.run_internal_fast = frc_en_r & fh_run & !sel_r.high_source_select;
  assign osc_ctl.run_external_fast = fxt_en_r & fh_run & sel_r.high_source_select;
  assign osc_ctl.run_internal_slow = fsub_run & !sel_r.low_source_select;
  assign osc_ctl.run_external_slow = sxt_en_r & fsub_run & sel_r.low_source_select;
  assign osc_ctl.fast_rc_freq      = frc_applied_r;

  // synchronous divider counts fast ticks for the divided rates
  always_comb
  begin
    div_nxt = fast_tick ? div_r + 6'h1 : div_r;
  end

  // code k up to 6 ticks once every 2^k fast ticks, code 7 is the sub tick
  assign cand_tick[0] = fast_tick;
  genvar gi;
  generate
    for (gi = 1; gi < 7; gi++)
    begin : g_div
      assign cand_tick[gi] = fast_tick & (&div_r[gi-1:0]);
    end
  endgenerate
  assign cand_tick[7] = sub_tick;

  scs_clk_switch u_switch (
    .pclk      (pclk),
    .presetn   (presetn),
    .cand_tick (cand_tick),
    .req_code  (sel_r.sys_clock_selector),
    .sys_tick  (sw_tick),
    .cur_code  (cur_code),
    .busy      (switch_busy),
    .done      (sw_done)
  );

  // cpu clock stops in every halted mode
  assign sys_tick = sw_tick & !halted_r;

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: switch done, fast rc stable, halt entered; set beats clear
  assign events = {halt_req & !halted_r, frc_flag_nxt & !frc_flag_r, sw_done};
  always_comb
  begin
    irq_stat_nxt = irq_stat_r;
    if (wr && paddr == `SCS_OFF_IRQ_STAT)
      irq_stat_nxt = irq_stat_r & ~pwdata[2:0];
    irq_stat_nxt = irq_stat_nxt | events;
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // all state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_r         <= scs_sel_t'(`SCS_SEL_RESET);
      frc_freq_r    <= 2'(`SCS_FRC_RESET >> `SCS_FRC_FREQ_LO);
      frc_applied_r <= 2'(`SCS_FRC_RESET >> `SCS_FRC_FREQ_LO);
      frc_en_r      <= 1'b1;
      frc_flag_r    <= 1'b0;
      frc_cnt_r     <= 8'h0;
      fxt_mode_r    <= 1'b0;
      fxt_en_r      <= 1'b0;
      sxt_en_r      <= 1'b0;
      irq_stat_r    <= `SCS_IRQ_RESET;
      irq_mask_r    <= `SCS_IRQ_RESET;
      halted_r      <= 1'b0;
      ack_r         <= 1'b0;
      prdata_r      <= 32'h0;
      slverr_r      <= 1'b0;
      div_r         <= 6'h0;
    end
    else
    begin
      sel_r         <= sel_nxt;
      frc_freq_r    <= frc_freq_nxt;
      frc_applied_r <= frc_applied_nxt;
      frc_en_r      <= frc_en_nxt;
      frc_flag_r    <= frc_flag_nxt;
      frc_cnt_r     <= frc_cnt_nxt;
      fxt_mode_r    <= fxt_mode_nxt;
      fxt_en_r      <= fxt_en_nxt;
      sxt_en_r      <= sxt_en_nxt;
      irq_stat_r    <= irq_stat_nxt;
      irq_mask_r    <= irq_mask_nxt;
      halted_r      <= halted_nxt;
      ack_r         <= ack_nxt;
      prdata_r      <= prdata_nxt;
      slverr_r      <= slverr_nxt;
      div_r         <= div_nxt;
    end
  end

  assign pready  = ack_r;
  assign prdata  = prdata_r;
  assign pslverr = slverr_r & ack_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_sub_route;
    @(posedge pclk) disable iff (!presetn)
      (cur_code == 3'h7 && !switch_busy && !halted_r) |->
        (sys_tick == sub_tick);
  endproperty
  a_sub_route: assert property (p_sub_route)
    else $error("sub code does not route sub clock");

  property p_rsvd_zero;
    @(posedge pclk) disable iff (!presetn)
      (acc && paddr == 12'h004) |=> prdata[31:4] == 28'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");

  property p_high_src;
    @(posedge pclk) disable iff (!presetn)
      (fh_run && !sel_r.high_source_select) |-> fast_tick == internal_fast_osc;
  endproperty
  a_high_src: assert property (p_high_src)
    else $error("fast source routing wrong");

  property p_low_src;
    @(posedge pclk) disable iff (!presetn)
      (fsub_run && sel_r.low_source_select) |-> sub_tick == external_slow_crystal;
  endproperty
  a_low_src: assert property (p_low_src)
    else $error("slow source routing wrong");

  property p_halt_fast;
    @(posedge pclk) disable iff (!presetn)
      (halted_r && !sel_r.high_idle_enable) |-> !fast_tick && !sys_tick;
  endproperty
  a_halt_fast: assert property (p_halt_fast)
    else $error("fast clock runs in halt");

  property p_halt_slow;
    @(posedge pclk) disable iff (!presetn)
      (halted_r && !sel_r.low_idle_enable) |-> !sub_tick;
  endproperty
  a_halt_slow: assert property (p_halt_slow)
    else $error("slow clock runs in halt");

  property p_frc_restart;
    @(posedge pclk) disable iff (!presetn)
      (frc_en_nxt && !frc_en_r) |=> !frc_flag_r ##1 !frc_flag_r;
  endproperty
  a_frc_restart: assert property (p_frc_restart)
    else $error("stable flag not cleared on enable");

  property p_freq_apply;
    @(posedge pclk) disable iff (!presetn)
      $changed(frc_applied_r) |-> $rose(frc_flag_r);
  endproperty
  a_freq_apply: assert property (p_freq_apply)
    else $error("frequency applied before stable");

  property p_mode_sleep;
    @(posedge pclk) disable iff (!presetn)
      (halted_r && !sel_r.high_idle_enable && !sel_r.low_idle_enable) |->
        power_mode == SCS_SLEEP;
  endproperty
  a_mode_sleep: assert property (p_mode_sleep)
    else $error("sleep mode not selected");
endmodule

// >>> tb/system_clock_select_control_test.sv
// self-checking bench for the clock select block
`timescale 1ns/1ps
module system_clock_select_control_test;
  import scs_pkg::*;
  `include "scs_defines.svh"
  // compare, count, report
  `define CHK(nm, ex, got) begin n_tests++; if ((ex) !== (got)) begin err_total++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, cyc, r;
  logic         internal_fast_osc, external_fast_crystal, internal_slow_osc;
  logic         external_slow_crystal, fast_crystal_ready, slow_crystal_ready;
  logic         halt_req, wake_req, sys_tick, fast_tick, sub_tick, switch_busy, irq;
  scs_osc_ctl_t osc_ctl;
  scs_mode_t    power_mode;
  logic [33:0]  exp_q[$];
  logic [33:0]  e;
  int           err_total, n_tests, n, s, f, b, k, i, tc, tt;
  logic [2:0]   cur;
  scs_mode_t    em;

  scs_top u_scs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .internal_fast_osc(internal_fast_osc),
    .external_fast_crystal(external_fast_crystal), .internal_slow_osc(internal_slow_osc),
    .external_slow_crystal(external_slow_crystal), .fast_crystal_ready(fast_crystal_ready),
    .slow_crystal_ready(slow_crystal_ready), .halt_req(halt_req), .wake_req(wake_req),
    .sys_tick(sys_tick), .fast_tick(fast_tick), .sub_tick(sub_tick), .osc_ctl(osc_ctl),
    .power_mode(power_mode), .switch_busy(switch_busy), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, and oscillator ticks at fixed ratios so counts are exact
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc                   <= cyc + 32'h1;
    internal_fast_osc     <= cyc[0];
    external_fast_crystal <= (cyc[1:0] == 2'h0);
    internal_slow_osc     <= (cyc[3:0] == 4'h0);
    external_slow_crystal <= (cyc[4:0] == 5'h00);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: every answer consumes the oldest note
  always @(posedge pclk)
  begin
    if (presetn && pready)
    begin
      if (exp_q.size() == 0)
        `CHK("unexpected answer", 1'b0, 1'b1)
      else
      begin
        e = exp_q.pop_front();
        `CHK("pslverr", e[32], pslverr)
        if (e[33])
          `CHK("prdata", e[31:0], prdata)
      end
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one apb transfer; the note is queued before the request goes out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic chk, input logic er);
    int t;
    exp_q.push_back({chk, er, d});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 50; t++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (t == 50)
    begin
      err_total++;
      print_verdict();
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // tick counts over a window
  task automatic count(input int c);
    s = 0;
    f = 0;
    b = 0;
    repeat (c)
    begin
      @(posedge pclk);
      s += sys_tick;
      f += fast_tick;
      b += sub_tick;
    end
  endtask

  // cycles from the selector write until the switch ends
  task automatic wait_switch();
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while ((n < 2 || switch_busy !== 1'b0) && n < 2000);
    if (n == 2000)
    begin
      err_total++;
      print_verdict();
    end
  endtask

  function automatic int tper(input logic [2:0] c);
    return (c == 3'h7) ? 16 : (2 << c);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, halt_req, wake_req} = 6'h0;
    {paddr, pwdata, cyc} = '0;
    {internal_fast_osc, external_fast_crystal, internal_slow_osc} = 3'h0;
    external_slow_crystal = 1'b0;
    fast_crystal_ready = 1'b1;
    slow_crystal_ready = 1'b1;
    err_total = 0;
    n_tests = 0;
    cur = 3'h0;
    void'($urandom(32'had801397));
    wait_cyc(10);
    presetn <= 1'b1;
    // register reset values and fast rc settling
    apb(1'b0, `SCS_OFF_SEL, 32'h00, 1'b1, 1'b0);
    apb(1'b0, `SCS_OFF_FRC, 32'h01, 1'b1, 1'b0);
    wait_cyc(110);
    apb(1'b0, `SCS_OFF_FRC, 32'h03, 1'b1, 1'b0);
    apb(1'b0, 12'h018, 32'h0, 1'b1, 1'b1);
    apb(1'b1, `SCS_OFF_FRC, 32'h0c, 1'b0, 1'b0);
    // field kept at 11 from the write before, reserved bits written as ones
    apb(1'b1, `SCS_OFF_FRC, 32'hfffffffd, 1'b0, 1'b0);
    apb(1'b0, `SCS_OFF_FRC, 32'h0d, 1'b1, 1'b0);
    `CHK("fast_rc_freq early", 2'h0, osc_ctl.fast_rc_freq)
    wait_cyc(110);
    apb(1'b0, `SCS_OFF_FRC, 32'h0f, 1'b1, 1'b0);
    `CHK("fast_rc_freq", 2'h3, osc_ctl.fast_rc_freq)
    $display("test reset_and_fast_rc done");
    // every selector code: switch delay and divided rate
    for (i = 1; i <= 8; i++)
    begin
      k = i % 8;
      tc = tper(cur);
      tt = tper(k[2:0]);
      apb(1'b1, `SCS_OFF_SEL, {24'h0, k[2:0], 5'h00}, 1'b0, 1'b0);
      wait_switch();
      `CHK("switch not too soon", 1'b1, n >= 3 * tc)
      `CHK("switch bounded", 1'b1, n <= 6 * tc + tt + 4)
      cur = k[2:0];
      count(256);
      `CHK("sys ticks", (k == 7) ? 16 : (128 >> k), s)
    end
    $display("test selector_codes done");
    // source selects, crystals enabled
    apb(1'b1, `SCS_OFF_FXT, 32'h1, 1'b0, 1'b0);
    apb(1'b1, `SCS_OFF_SXT, 32'h1, 1'b0, 1'b0);
    apb(1'b1, `SCS_OFF_SEL, 32'h0c, 1'b0, 1'b0);
    wait_cyc(40);
    count(256);
    `CHK("fast from crystal", 64, f)
    `CHK("sub from crystal", 8, b)
    apb(1'b1, `SCS_OFF_SEL, 32'h00, 1'b0, 1'b0);
    wait_cyc(40);
    count(256);
    `CHK("fast from rc", 128, f)
    `CHK("sub from rc", 16, b)
    r = $urandom();
    apb(1'b1, `SCS_OFF_SXT, r, 1'b0, 1'b0);
    apb(1'b0, `SCS_OFF_SXT, {30'h0, r[0], r[0]}, 1'b1, 1'b0);
    apb(1'b1, `SCS_OFF_SXT, 32'h1, 1'b0, 1'b0);
    $display("test sources done");
    // halt with every pair of idle bits
    for (k = 0; k < 4; k++)
    begin
      r = $urandom();
      apb(1'b1, `SCS_OFF_SEL, {r[31:8], 3'h0, r[4], 2'h0, k[1:0]}, 1'b0, 1'b0);
      apb(1'b0, `SCS_OFF_SEL, {30'h0, k[1:0]}, 1'b1, 1'b0);
      halt_req <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
      wait_cyc(2);
      em = (k == 0) ? SCS_SLEEP : (k == 1) ? SCS_IDLE_LOW_ONLY :
           (k == 3) ? SCS_IDLE_BOTH_CLOCKS : SCS_IDLE_HIGH_ONLY;
      `CHK("halt mode", em, power_mode)
      `CHK("fast rc run", k[1], osc_ctl.run_internal_fast)
      count(64);
      `CHK("fast ticks halted", k[1] ? 32 : 0, f)
      `CHK("sub ticks halted", k[0] ? 4 : 0, b)
      `CHK("sys ticks halted", 0, s)
      wake_req <= 1'b1;
      @(posedge pclk);
      wake_req <= 1'b0;
      wait_cyc(2);
      `CHK("woken mode", SCS_FAST, power_mode)
    end
    $display("test halt_modes done");
    // interrupt: masked, raised, cleared
    apb(1'b1, `SCS_OFF_IRQ_MASK, 32'h0, 1'b0, 1'b0);
    wait_cyc(2);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, `SCS_OFF_IRQ_MASK, 32'h1, 1'b0, 1'b0);
    wait_cyc(2);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, `SCS_OFF_IRQ_STAT, 32'h7, 1'b0, 1'b0);
    wait_cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    $display("test interrupt done");
    wait_cyc(4);
    print_verdict();
  end
endmodule
